// ### hdl/hdsp_pkg.sv
// package: constants and types of the halt dispatch state machine
package hdsp_pkg;

   // ----------------------------------------------------------------
   // control word field positions
   // ----------------------------------------------------------------
   localparam int CW_W = 16;
   localparam int CW_RESTART = 0;
   localparam int CW_BOOT = 1;
   localparam int CW_DIAG = 2;
   localparam int CW_TRACE = 3;
   localparam int CW_ERR = 4;
   localparam int CW_HALT_EN = 5;
   localparam int CW_UA_LO = 6;
   localparam int CW_MB_LO = 9;
   localparam int CW_HC_LO = 11;
   localparam int CW_HT_LO = 13;

   // ----------------------------------------------------------------
   // source bit positions
   // ----------------------------------------------------------------
   localparam int MBX_RESTART_BIT = 3;
   localparam int MBX_BOOT_BIT = 2;
   localparam int MBX_ACT_LO = 0;
   localparam int DIAG_REG_HALT_EN_BIT = 7;
   localparam int SSW_CODE_LO = 8;

   // ----------------------------------------------------------------
   // halt type, halt code, mailbox and user action encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] HT_POWERUP = 3'h0;
   localparam logic [2:0] HT_IN_PROG = 3'h1;
   localparam logic [2:0] HT_SUPPLY = 3'h2;
   localparam logic [2:0] HT_BREAK = 3'h3;
   localparam logic [2:0] HT_BUS_HALT = 3'h4;
   localparam logic [2:0] HT_REMOTE = 3'h5;
   localparam logic [1:0] HC_EXT = 2'h0;
   localparam logic [1:0] HC_RESET = 2'h1;
   localparam logic [1:0] HC_INSTR = 2'h2;
   localparam logic [1:0] HC_OTHER = 2'h3;
   localparam logic [5:0] RC_EXT = 6'h02;
   localparam logic [5:0] RC_RESET = 6'h03;
   localparam logic [5:0] RC_INSTR = 6'h06;
   localparam logic [1:0] MB_RBH = 2'h0;
   localparam logic [1:0] MB_RH = 2'h1;
   localparam logic [1:0] MB_BH = 2'h2;
   localparam logic [1:0] MB_H = 2'h3;
   localparam logic [2:0] UA_DEF = 3'h0;
   localparam logic [2:0] UA_RH = 3'h1;
   localparam logic [2:0] UA_BH = 3'h2;
   localparam logic [2:0] UA_H = 3'h3;
   localparam logic [2:0] UA_RBH = 3'h4;

   // ----------------------------------------------------------------
   // register map (byte addresses) and field positions
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_WORD = 4'h8;
   localparam logic [3:0] REG_COUNT = 4'hC;
   localparam int CTRL_START = 0;
   localparam int CTRL_STEP_MODE = 1;
   localparam int CTRL_STEP = 2;
   localparam int CTRL_UA_LO = 4;
   localparam int ST_RUN = 8;
   localparam int ST_DONE = 9;
   localparam int ST_BOOT_SEEN = 10;
   localparam int ST_REST_SEEN = 11;
   localparam int ST_HALT_SEEN = 12;
   localparam logic [2:0] UA_RESET = 3'h0;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // dispatcher states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_ENTRY, S_RESET_INIT, S_BREAK_INIT, S_TRACE_INIT, S_OTHER_INIT, S_INIT,
      S_BOOTSTRAP, S_RESTART, S_HALT, S_TRACE, S_EXIT
   } hdsp_state_type;

endpackage : hdsp_pkg

// ### hdl/hdsp_word.sv
// control word assembly from live machine state
`timescale 1ns/100ps
module hdsp_word
   import hdsp_pkg::*;
(
   // machine state sources
   input wire logic [2:0] halt_type,
   input wire logic [31:0] saved_status_word,
   input wire logic [7:0] console_mailbox,
   input wire logic [7:0] boot_diag_reg,
   input wire logic [2:0] user_action,
   input wire logic err_flag,
   input wire logic trace_active_flag,
   input wire logic diag_active_flag,
   // packed result
   output logic [CW_W-1:0] ctl_word
);

   // ----------------------------------------------------------------
   // halt code compression
   // ----------------------------------------------------------------
   function automatic logic [1:0] squeeze(input logic [5:0] rc);
      if (rc == RC_EXT) begin
         squeeze = HC_EXT;
      end else if (rc == RC_RESET) begin
         squeeze = HC_RESET;
      end else if (rc == RC_INSTR) begin
         squeeze = HC_INSTR;
      end else begin
         squeeze = HC_OTHER;
      end
   endfunction : squeeze

   // purely combinational: rebuilt every cycle, never held from entry
   always_comb begin
      ctl_word = {halt_type,
                  squeeze(saved_status_word[SSW_CODE_LO +: 6]),
                  console_mailbox[MBX_ACT_LO +: 2],
                  user_action,
                  boot_diag_reg[DIAG_REG_HALT_EN_BIT],
                  err_flag,
                  trace_active_flag,
                  diag_active_flag,
                  console_mailbox[MBX_BOOT_BIT],
                  console_mailbox[MBX_RESTART_BIT]};
   end

endmodule : hdsp_word

// ### hdl/hdsp_dispatch.sv
// halt dispatch state machine with its avalon register slave
`timescale 1ns/100ps
module hdsp_dispatch
   import hdsp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // processor halt reporting
   input wire logic halt_entry,
   input wire logic [2:0] halt_type,
   input wire logic [31:0] saved_status_word,
   input wire logic [7:0] console_mailbox,
   input wire logic [7:0] boot_diag_reg,
   input wire logic err_flag,
   input wire logic trace_active_flag,
   input wire logic diag_active_flag,
   // outcome towards the action logic
   output logic [3:0] state_code,
   output logic do_bootstrap,
   output logic do_restart,
   output logic do_halt,
   output logic exit_done,
   output logic busy,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------
   logic rst_meta_n;
   logic rst_n;

   // release is synchronised so all state leaves reset on one edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   hdsp_state_type state;
   hdsp_state_type next_state;
   logic [CW_W-1:0] ctl_word;
   logic [2:0] user_action;
   logic step_mode;
   logic run;
   logic done_seen;
   logic boot_seen;
   logic rest_seen;
   logic halt_seen;
   logic [15:0] trans_count;
   logic bus_req;
   logic bus_take;
   logic bus_wr;
   logic sw_start;
   logic start;
   logic advance;

   // ----------------------------------------------------------------
   // control word source
   // ----------------------------------------------------------------
   hdsp_word u_word (
      .halt_type(halt_type),
      .saved_status_word(saved_status_word),
      .console_mailbox(console_mailbox),
      .boot_diag_reg(boot_diag_reg),
      .user_action(user_action),
      .err_flag(err_flag),
      .trace_active_flag(trace_active_flag),
      .diag_active_flag(diag_active_flag),
      .ctl_word(ctl_word)
   );

   // ----------------------------------------------------------------
   // transition table search
   // ----------------------------------------------------------------
   // each if-chain below keeps the table's row order, so an earlier
   // row always shadows a later one
   function automatic hdsp_state_type search(input hdsp_state_type s,
                                             input logic [CW_W-1:0] w);
      logic [2:0] ht;
      logic [1:0] hc;
      logic [1:0] mb;
      logic [2:0] ua;
      logic halt_en;
      logic err;
      logic trace;
      logic diag;
      logic boot;
      logic rstrt;
      logic clean;
      logic fail_ok;
      ht = w[CW_HT_LO +: 3];
      hc = w[CW_HC_LO +: 2];
      mb = w[CW_MB_LO +: 2];
      ua = w[CW_UA_LO +: 3];
      halt_en = w[CW_HALT_EN];
      err = w[CW_ERR];
      trace = w[CW_TRACE];
      diag = w[CW_DIAG];
      boot = w[CW_BOOT];
      rstrt = w[CW_RESTART];
      clean = !err && !trace && !diag && !boot && !rstrt;
      fail_ok = !trace && !diag && !boot;
      search = S_HALT;
      unique case (s)
         S_ENTRY: begin
            if (hc == HC_RESET) begin
               search = S_RESET_INIT;
            end else if (hc == HC_EXT && ht == HT_BREAK) begin
               search = S_BREAK_INIT;
            end else if (hc == HC_INSTR && !err && trace) begin
               search = S_TRACE_INIT;
            end else begin
               search = S_OTHER_INIT;
            end
         end
         S_RESET_INIT, S_BREAK_INIT, S_TRACE_INIT, S_OTHER_INIT: begin
            search = S_INIT;
         end
         S_INIT: begin
            if (hc == HC_EXT) begin
               // type consulted only under external code
               if ((ht == HT_SUPPLY && !halt_en) || ht == HT_REMOTE) begin
                  search = S_BOOTSTRAP;
               end else begin
                  search = S_HALT;
               end
            end else if (hc == HC_INSTR && trace) begin
               search = S_TRACE;
            end else if (hc == HC_RESET && clean &&
                         (!halt_en || ua == UA_BH || ua == UA_RBH)) begin
               search = S_BOOTSTRAP;
            end else if (hc[1] && clean &&
                         (mb == MB_BH || (mb == MB_RBH && ua == UA_BH))) begin
               search = S_BOOTSTRAP;
            end else if (hc[1] && mb == MB_RBH && fail_ok &&
                         ((ua == UA_RBH && !err && rstrt) ||
                          (ua == UA_RBH && err) ||
                          (ua == UA_DEF && !halt_en && !err && rstrt))) begin
               search = S_BOOTSTRAP;
            end else if (hc[1] && clean &&
                         (mb == MB_RH ||
                          (mb == MB_RBH && (ua == UA_RH || ua == UA_RBH)) ||
                          (mb == MB_RBH && ua == UA_DEF && !halt_en))) begin
               search = S_RESTART;
            end else begin
               search = S_HALT;
            end
         end
         S_TRACE: begin
            if (hc == HC_INSTR && trace && !err) begin
               search = S_EXIT;
            end else begin
               search = S_HALT;
            end
         end
         S_BOOTSTRAP, S_RESTART, S_HALT: begin
            search = err ? S_HALT : S_EXIT;
         end
         S_EXIT: begin
            search = S_HALT;
         end
      endcase
   endfunction : search

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   assign bus_req = avs_read || avs_write;
   // a request is taken on the edge where waitrequest is seen low
   assign bus_take = bus_req && !avs_waitrequest;
   assign bus_wr = bus_take && avs_write && avs_address == REG_CTRL &&
                   avs_byteenable[0];
   assign sw_start = bus_wr && avs_writedata[CTRL_START];
   assign start = halt_entry || sw_start;
   // in step mode software releases one transition per step write
   assign advance = run && (!step_mode ||
                    (bus_wr && avs_writedata[CTRL_STEP]));
   assign next_state = search(state, ctl_word);

   // one wait cycle per access, then a one-cycle answer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(bus_req && avs_waitrequest);
      end
   end

   // read data captured together with the falling waitrequest
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            REG_CTRL: begin
               avs_readdata <= {25'h0000000, user_action, 2'h0,
                                step_mode, 1'b0};
            end
            REG_STATUS: begin
               avs_readdata <= {19'h00000, halt_seen, rest_seen, boot_seen,
                                done_seen, run, 4'h0, state};
            end
            REG_WORD: begin
               avs_readdata <= {16'h0000, ctl_word};
            end
            REG_COUNT: begin
               avs_readdata <= {16'h0000, trans_count};
            end
            default: begin
               avs_readdata <= 32'h00000000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // software controls
   // ----------------------------------------------------------------
   // user action stands for the console halt setting
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         user_action <= UA_RESET;
         step_mode <= 1'b0;
      end else if (bus_wr) begin
         user_action <= avs_writedata[CTRL_UA_LO +: 3];
         step_mode <= avs_writedata[CTRL_STEP_MODE];
      end
   end

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   // start wins over a pending step; reset parks the machine at entry
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_ENTRY;
      end else if (start) begin
         state <= S_ENTRY;
      end else if (advance) begin
         state <= next_state;
      end
   end

   // running from a start until the handover at exit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
      end else if (start) begin
         run <= 1'b1;
      end else if (advance && next_state == S_EXIT) begin
         run <= 1'b0;
      end
   end

   // transition counter, cleared at each start, saturating
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trans_count <= COUNT_ZERO;
      end else if (start) begin
         trans_count <= COUNT_ZERO;
      end else if (advance && trans_count != 16'hFFFF) begin
         trans_count <= trans_count + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // sticky outcome record
   // ----------------------------------------------------------------
   // a new start clears the record of the previous dispatch
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_seen <= 1'b0;
         boot_seen <= 1'b0;
         rest_seen <= 1'b0;
         halt_seen <= 1'b0;
      end else if (start) begin
         done_seen <= 1'b0;
         boot_seen <= 1'b0;
         rest_seen <= 1'b0;
         halt_seen <= 1'b0;
      end else if (advance) begin
         done_seen <= done_seen || next_state == S_EXIT;
         boot_seen <= boot_seen || next_state == S_BOOTSTRAP;
         rest_seen <= rest_seen || next_state == S_RESTART;
         halt_seen <= halt_seen || next_state == S_HALT;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // outputs registered alongside the state register on the same edges, one cycle behind none
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_code <= 4'h0;
         do_bootstrap <= 1'b0;
         do_restart <= 1'b0;
         do_halt <= 1'b0;
         busy <= 1'b0;
      end else if (start) begin
         state_code <= S_ENTRY;
         do_bootstrap <= 1'b0;
         do_restart <= 1'b0;
         do_halt <= 1'b0;
         busy <= 1'b1;
      end else if (advance) begin
         state_code <= next_state;
         do_bootstrap <= next_state == S_BOOTSTRAP;
         do_restart <= next_state == S_RESTART;
         do_halt <= next_state == S_HALT;
         busy <= next_state != S_EXIT;
      end
   end

   // completion pulse on the edge that enters exit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         exit_done <= 1'b0;
      end else begin
         exit_done <= !start && advance && next_state == S_EXIT;
      end
   end

endmodule : hdsp_dispatch

// ### testbench/hdsp_checker_asserts.sv
// checker: concurrent assertions on the dispatcher's ports
`timescale 1ns/100ps
module hdsp_checker
   import hdsp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // halt reporting
   input wire logic halt_entry,
   input wire logic [2:0] halt_type,
   input wire logic [31:0] saved_status_word,
   input wire logic err_flag,
   input wire logic trace_active_flag,
   // outcome
   input wire logic [3:0] state_code,
   input wire logic do_bootstrap,
   input wire logic do_restart,
   input wire logic do_halt,
   input wire logic exit_done,
   input wire logic busy,
   // bus handshake
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a fresh start owns the next edge, so transition checks stand aside
   logic quiet;
   logic [5:0] reason;
   assign quiet = !halt_entry && !avs_write;
   assign reason = saved_status_word[13:8];
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_start_entry: assert property (
      halt_entry |=> state_code == 4'h0 && busy)
      else $error("start did not land in entry");
   a_entry_reset: assert property (
      state_code == 4'h0 && busy && quiet && reason == RC_RESET |=> state_code == 4'h1)
      else $error("power-up entry missed reset init");
   a_entry_break: assert property (
      state_code == 4'h0 && busy && quiet && reason == RC_EXT && halt_type == HT_BREAK |=> state_code == 4'h2)
      else $error("break entry missed break init");
   a_init_common: assert property (
      state_code inside {4'h1, 4'h2, 4'h3, 4'h4} && quiet |=> state_code == 4'h5)
      else $error("init variant did not reach common init");
   a_clean_exit: assert property (
      state_code inside {4'h6, 4'h7, 4'h8} && !err_flag && quiet |=> state_code == 4'hA && exit_done && !busy)
      else $error("clean outcome did not exit");
   a_error_halts: assert property (
      state_code inside {4'h6, 4'h7, 4'h8} && err_flag && quiet |=> state_code == 4'h8 && !exit_done)
      else $error("error did not fall to halt");
   a_trace_exit: assert property (
      state_code == 4'h9 && reason == RC_INSTR && trace_active_flag && !err_flag && quiet |=> state_code == 4'hA)
      else $error("trace did not exit");
   a_action_levels: assert property (
      do_bootstrap == (state_code == 4'h6) && do_restart == (state_code == 4'h7) && do_halt == (state_code == 4'h8))
      else $error("action level disagrees with state");
   a_exit_pulse: assert property (
      exit_done |-> state_code == 4'hA && !busy && $past(busy) ##1 !exit_done)
      else $error("completion pulse malformed");
   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");
endmodule : hdsp_checker

// ### testbench/hdsp_cpu_model.sv
// model: processor halt reporting and console mailbox sources
`timescale 1ns/100ps
module hdsp_cpu_model (
   // clock
   input wire logic core_clk,
   // settings: flags are halt enable, error, trace, diag, boot, restart
   input wire logic [2:0] set_type,
   input wire logic [5:0] set_reason,
   input wire logic [1:0] set_mbx,
   input wire logic [5:0] set_flags,
   // towards the dispatcher
   output logic [2:0] halt_type,
   output logic [31:0] saved_status_word,
   output logic [7:0] console_mailbox,
   output logic [7:0] boot_diag_reg,
   output logic err_flag,
   output logic trace_active_flag,
   output logic diag_active_flag
);
   // unrelated bits flip every cycle so the decoder cannot lean on them
   logic [31:0] noise = 32'hA5C396F0;
   always @(posedge core_clk) begin
      noise <= ~noise;
   end
   // live sources, rebuilt at once when the bench moves a setting
   assign halt_type = set_type;
   assign saved_status_word = {noise[31:14], set_reason, noise[7:0]};
   assign console_mailbox = {noise[7:4], set_flags[0], set_flags[1], set_mbx};
   assign boot_diag_reg = {set_flags[5], noise[6:0]};
   assign err_flag = set_flags[4];
   assign trace_active_flag = set_flags[3];
   assign diag_active_flag = set_flags[2];
endmodule : hdsp_cpu_model

// ### testbench/halt_dispatch_fsm_bench.sv
// testbench: halt dispatcher against its documented transitions
`timescale 1ns/100ps
module halt_dispatch_fsm_bench
   import hdsp_pkg::*;
   ;
   logic core_clk = 1'h0;
   logic arst_n = 1'h0;
   logic halt_entry = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [2:0] set_type = 3'h0;
   logic [5:0] set_reason = 6'h03;
   logic [1:0] set_mbx = 2'h0;
   logic [5:0] set_flags = 6'h00;
   logic [2:0] halt_type;
   logic [31:0] saved_status_word, avs_readdata, rd;
   logic [7:0] console_mailbox, boot_diag_reg;
   logic err_flag, trace_active_flag, diag_active_flag, do_bootstrap, do_restart, do_halt, exit_done, busy;
   logic avs_waitrequest;
   logic [3:0] state_code;
   int err_total = 0;
   int checked = 0;
   // ----------------------------------------------------------------
   // clock, instances, common tasks
   // ----------------------------------------------------------------
   always #25 core_clk = ~core_clk;
   hdsp_cpu_model cpu (.core_clk, .set_type, .set_reason, .set_mbx, .set_flags, .halt_type, .saved_status_word,
      .console_mailbox, .boot_diag_reg, .err_flag, .trace_active_flag, .diag_active_flag);
   hdsp_dispatch uut (.core_clk, .arst_n, .halt_entry, .halt_type, .saved_status_word, .console_mailbox,
      .boot_diag_reg, .err_flag, .trace_active_flag, .diag_active_flag, .state_code, .do_bootstrap, .do_restart,
      .do_halt, .exit_done, .busy, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest);
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task summarize;
      if (err_total == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // one bus cycle; held until waitrequest is sampled low, read data kept in rd
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   // one halt: init state after 2 edges, outcome after 4, exit after that
   task automatic run_case(input logic [2:0] ht, input logic [5:0] rc, input logic [1:0] mbx, input logic [2:0] ua,
      input logic [5:0] fl, input logic [3:0] ini, input logic [3:0] outc);
      bus(1'h1, REG_CTRL, {25'h0, ua, 4'h0});
      @(posedge core_clk);
      {set_type, set_reason, set_mbx, set_flags} <= {ht, rc, mbx, fl};
      halt_entry <= 1'h1;
      @(posedge core_clk);
      halt_entry <= 1'h0;
      @(posedge core_clk);
      @(negedge core_clk);
      check({28'h0, state_code}, {28'h0, ini});
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check({28'h0, state_code}, {28'h0, outc});
      @(posedge core_clk);
      @(negedge core_clk);
      if (fl[4]) begin
         check({28'h0, state_code}, 32'h8);
         @(posedge core_clk);
         set_flags <= fl & 6'h2F;
         @(posedge core_clk);
         @(negedge core_clk);
      end
      check({31'h0, exit_done}, 32'h1);
      check({28'h0, state_code}, 32'hA);
   endtask : run_case
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task reg_access;
      @(posedge core_clk);
      {set_type, set_reason, set_mbx, set_flags} <= {3'h5, 6'h06, 2'h2, 6'h2B};
      bus(1'h1, REG_CTRL, 32'h30);
      avs_byteenable <= 4'hE;
      bus(1'h1, REG_CTRL, 32'h40);
      avs_byteenable <= 4'hF;
      bus(1'h0, REG_CTRL, 32'h0);
      check(rd, 32'h30);
      bus(1'h0, REG_WORD, 32'h0);
      check({16'h0, rd[15:0]}, {16'h0, 3'h5, 2'h2, 2'h2, 3'h3, 6'h2B});
      bus(1'h0, 4'h2, 32'h0);
      check(rd, 32'h0);
   endtask : reg_access
   task powerup_halts;
      run_case(3'h0, 6'h03, 2'h3, 3'h0, 6'h00, 4'h1, 4'h6);
      run_case(3'h0, 6'h03, 2'h3, 3'h2, 6'h20, 4'h1, 4'h6);
      run_case(3'h0, 6'h03, 2'h3, 3'h4, 6'h20, 4'h1, 4'h6);
      run_case(3'h0, 6'h03, 2'h3, 3'h0, 6'h20, 4'h1, 4'h8);
      run_case(3'h0, 6'h03, 2'h3, 3'h0, 6'h04, 4'h1, 4'h8);
   endtask : powerup_halts
   task ext_halts;
      run_case(3'h3, 6'h02, 2'h0, 3'h0, 6'h00, 4'h2, 4'h8);
      run_case(3'h2, 6'h02, 2'h0, 3'h0, 6'h00, 4'h4, 4'h6);
      run_case(3'h2, 6'h02, 2'h0, 3'h0, 6'h20, 4'h4, 4'h8);
      run_case(3'h5, 6'h02, 2'h0, 3'h0, 6'h20, 4'h4, 4'h6);
      run_case(3'h4, 6'h02, 2'h0, 3'h0, 6'h00, 4'h4, 4'h8);
      run_case(3'h1, 6'h02, 2'h0, 3'h0, 6'h00, 4'h4, 4'h8);
      run_case(3'h3, 6'h06, 2'h3, 3'h0, 6'h00, 4'h4, 4'h8);
   endtask : ext_halts
   task trace_halts;
      run_case(3'h0, 6'h06, 2'h3, 3'h0, 6'h08, 4'h3, 4'h9);
      run_case(3'h0, 6'h06, 2'h3, 3'h0, 6'h18, 4'h4, 4'h9);
   endtask : trace_halts
   task os_halts;
      run_case(3'h0, 6'h04, 2'h2, 3'h0, 6'h00, 4'h4, 4'h6);
      run_case(3'h0, 6'h04, 2'h0, 3'h2, 6'h20, 4'h4, 4'h6);
      run_case(3'h0, 6'h04, 2'h0, 3'h4, 6'h01, 4'h4, 4'h6);
      run_case(3'h0, 6'h04, 2'h0, 3'h4, 6'h10, 4'h4, 4'h6);
      run_case(3'h0, 6'h04, 2'h0, 3'h0, 6'h01, 4'h4, 4'h6);
      run_case(3'h0, 6'h04, 2'h1, 3'h0, 6'h00, 4'h4, 4'h7);
      run_case(3'h0, 6'h04, 2'h0, 3'h1, 6'h00, 4'h4, 4'h7);
      run_case(3'h0, 6'h04, 2'h0, 3'h4, 6'h00, 4'h4, 4'h7);
      run_case(3'h0, 6'h04, 2'h0, 3'h0, 6'h00, 4'h4, 4'h7);
      run_case(3'h0, 6'h04, 2'h0, 3'h0, 6'h20, 4'h4, 4'h8);
      run_case(3'h0, 6'h04, 2'h0, 3'h3, 6'h00, 4'h4, 4'h8);
      run_case(3'h0, 6'h04, 2'h3, 3'h0, 6'h00, 4'h4, 4'h8);
      run_case(3'h0, 6'h04, 2'h2, 3'h0, 6'h02, 4'h4, 4'h8);
      run_case(3'h0, 6'h06, 2'h2, 3'h0, 6'h00, 4'h4, 4'h6);
   endtask : os_halts
   // register start in step mode holds at entry; a step that also leaves step mode runs on
   task ctrl_start;
      @(posedge core_clk);
      {set_reason, set_mbx, set_flags} <= {6'h04, 2'h1, 6'h00};
      bus(1'h1, REG_CTRL, 32'h3);
      bus(1'h0, REG_STATUS, 32'h0);
      check(rd, 32'h00000100);
      bus(1'h1, REG_CTRL, 32'h4);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check({31'h0, exit_done}, 32'h1);
      bus(1'h0, REG_STATUS, 32'h0);
      check(rd, 32'h00000A0A);
      bus(1'h0, REG_COUNT, 32'h0);
      check(rd, 32'h4);
   endtask : ctrl_start
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge core_clk);
      reg_access;
      powerup_halts;
      ext_halts;
      trace_halts;
      os_halts;
      ctrl_start;
      summarize;
   end
   initial begin
      #1000000;
      err_total++;
      summarize;
   end
endmodule : halt_dispatch_fsm_bench
bind hdsp_dispatch hdsp_checker chk (.core_clk, .arst_n, .halt_entry, .halt_type, .saved_status_word, .err_flag,
   .trace_active_flag, .state_code, .do_bootstrap, .do_restart, .do_halt, .exit_done, .busy, .avs_read,
   .avs_write, .avs_waitrequest);
